// ==== rtl/cfm_pkg.sv ====
// Package for the cache flush and memory fence unit.
// Assumes a single core clock domain; shared by the unit and its bench.
package cfm_pkg;

    // ------------------------------------------------------------------
    // Operation codes and widths
    // ------------------------------------------------------------------
    localparam int ADDR_W     = 32;
    localparam int VEC_W      = 128;
    localparam int GPR_W      = 32;
    localparam int MASK_W     = VEC_W / 8;
    localparam int CNT_W      = 4;
    localparam int FEAT_BIT   = 19;                 // Line flush feature flag position.
    localparam logic [7:0] ID_LEAF_FEATURES = 8'h01;
    localparam int PAUSE_CYCLES = 8;                // Hold time of a spin-wait pause.

    typedef enum logic [3:0] {
        CFM_OP_NONE       = 4'h0,
        CFM_OP_LOAD       = 4'h1,
        CFM_OP_STORE      = 4'h2,
        CFM_OP_FLUSH      = 4'h3,
        CFM_OP_NT_VEC_INT = 4'h4,
        CFM_OP_NT_VEC_DBL = 4'h5,
        CFM_OP_NT_GPR     = 4'h6,
        CFM_OP_NT_MASKED  = 4'h7,
        CFM_OP_LOAD_BAR   = 4'h8,
        CFM_OP_FULL_BAR   = 4'h9,
        CFM_OP_STORE_BAR  = 4'ha,
        CFM_OP_PAUSE      = 4'hb
    } cfm_op_t;

    // Request from the pipeline.
    typedef struct packed {
        cfm_op_t              op;
        logic [ADDR_W-1:0]    addr;
        logic [VEC_W-1:0]     data;
        logic [MASK_W-1:0]    mask;
    } cfm_req_t;

    // Request to the memory side.
    typedef struct packed {
        logic                 is_load;
        logic                 is_flush;   // Write back then invalidate all levels.
        logic                 broadcast;  // Invalidate snooped to every coherent agent.
        logic                 no_alloc;   // Non-temporal: bypass all cache levels.
        logic [ADDR_W-1:0]    addr;
        logic [VEC_W-1:0]     data;
        logic [MASK_W-1:0]    byte_en;
    } cfm_mem_req_t;

endpackage : cfm_pkg

// ==== rtl/cfm_unit.sv ====
// Cache flush, non-temporal store, fence and pause unit.
// Assumes the memory side answers each load and each store/flush with one
// completion pulse once the access is globally observable.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - A line flush writes back dirty data of the addressed line and invalidates it at all levels.
// - The invalidation of a line flush is broadcast to every agent of the coherency domain.
// - The feature word returned for leaf 01H has bit 19 set to show the line flush exists.
// - Every non-temporal store goes to memory without allocating in any cache level.
// - The non-temporal vector integer store writes all 128 bits of the vector register.
// - The non-temporal vector double store writes the packed doubles of the vector register.
// - The non-temporal word store writes the general register value.
// - The masked byte store writes only mask-selected bytes, at any alignment, non-temporally.
// - A load barrier lets no later load issue until all earlier loads have completed.
// - A full barrier lets no later access start until all earlier ones are observable.
// - A pause holds issue for a short while to ease spin-wait exit and save power.
module cfm_unit
    import cfm_pkg::*;
#(
    parameter int PAUSE_LEN = PAUSE_CYCLES
) (
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              rst_b,
    // Pipeline request
    input  wire logic              req_valid,
    input  wire cfm_req_t          req,
    output logic                   req_ready,
    output logic                   retire_pulse,
    // Identification query
    input  wire logic              id_query,
    input  wire logic [7:0]        id_leaf,
    output logic [31:0]            id_edx,
    // Memory side
    output logic                   mem_valid,
    output cfm_mem_req_t           mem_req,
    input  wire logic              mem_ready,
    input  wire logic              mem_load_done,
    input  wire logic              mem_store_done,
    // Status
    output logic                   pause_active
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    // The pause timer is eight bits wide and a zero length would never hold issue.
    if (PAUSE_LEN < 1 || PAUSE_LEN > 255) begin : g_bad_pause_len
        $error("PAUSE_LEN must be 1..255");
    end

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    logic [CNT_W-1:0] loads_out_reg;
    logic [CNT_W-1:0] stores_out_reg;
    logic [7:0]       pause_cnt_reg;
    logic             mem_valid_reg;
    cfm_mem_req_t     mem_req_reg;
    logic             req_ready_reg;
    logic             retire_reg;
    logic [31:0]      id_edx_reg;
    logic             pause_reg;

    wire logic is_load   = req.op == CFM_OP_LOAD;
    wire logic is_flush  = req.op == CFM_OP_FLUSH;
    wire logic is_nt     = req.op inside {CFM_OP_NT_VEC_INT, CFM_OP_NT_VEC_DBL,
                                          CFM_OP_NT_GPR, CFM_OP_NT_MASKED};
    wire logic is_store  = req.op == CFM_OP_STORE || is_nt || is_flush;
    wire logic is_lbar   = req.op == CFM_OP_LOAD_BAR;
    wire logic is_fbar   = req.op == CFM_OP_FULL_BAR;
    wire logic is_sbar   = req.op == CFM_OP_STORE_BAR;
    wire logic is_pause  = req.op == CFM_OP_PAUSE;
    wire logic is_mem    = is_load || is_store;

    // Drained status of the scoreboard, free request slot and running pause timer.
    wire logic loads_idle  = loads_out_reg == '0;
    wire logic stores_idle = stores_out_reg == '0;
    wire logic slot_free   = !mem_valid_reg || mem_ready;
    wire logic pausing     = pause_cnt_reg != 8'h00;

    // Barrier hold: the barrier itself waits until its earlier accesses drain.
    wire logic bar_hold = (is_lbar && !(loads_idle && slot_free && !mem_valid_reg))
                       || ((is_fbar || is_sbar)
                           && !(loads_idle && stores_idle && !mem_valid_reg));
    // Counter saturation stalls further issue instead of wrapping.
    wire logic cnt_full = (is_load && loads_out_reg == '1)
                       || (is_store && stores_out_reg == '1);

    wire logic take = req_valid && req_ready_reg && !pausing && !bar_hold
                   && !cnt_full && (!is_mem || slot_free);

    // ------------------------------------------------------------------
    // Byte enables and data shaping per store kind
    // ------------------------------------------------------------------
    logic [MASK_W-1:0] be_sel;
    logic [VEC_W-1:0]  data_sel;
    always_comb begin
        be_sel   = '1;
        data_sel = req.data;
        unique case (req.op)
            CFM_OP_NT_VEC_INT: be_sel = '1;
            CFM_OP_NT_VEC_DBL: be_sel = '1;
            CFM_OP_NT_GPR: begin
                be_sel   = MASK_W'({(GPR_W/8){1'b1}});
                data_sel = {{(VEC_W-GPR_W){1'b0}}, req.data[GPR_W-1:0]};
            end
            CFM_OP_NT_MASKED:  be_sel = req.mask;
            CFM_OP_LOAD, CFM_OP_FLUSH: be_sel = '0;
            default:           be_sel = '1;
        endcase
    end

    // ------------------------------------------------------------------
    // Memory request register
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            mem_valid_reg <= 1'b0;
            mem_req_reg   <= '0;
        end else if (take && is_mem) begin
            mem_valid_reg         <= 1'b1;
            mem_req_reg.is_load   <= is_load;
            mem_req_reg.is_flush  <= is_flush;
            mem_req_reg.broadcast <= is_flush;
            mem_req_reg.no_alloc  <= is_nt;
            mem_req_reg.addr      <= req.addr;                       // Unaligned allowed.
            mem_req_reg.data      <= data_sel;
            mem_req_reg.byte_en   <= be_sel;
        end else if (mem_ready) begin
            mem_valid_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Outstanding-access scoreboard
    // ------------------------------------------------------------------
    // A request is counted at acceptance so a barrier sees it at once.
    wire logic ld_inc = take && is_load;
    wire logic st_inc = take && is_store;
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            loads_out_reg  <= '0;
            stores_out_reg <= '0;
        end else begin
            loads_out_reg  <= loads_out_reg + CNT_W'(ld_inc) - CNT_W'(mem_load_done);
            stores_out_reg <= stores_out_reg + CNT_W'(st_inc) - CNT_W'(mem_store_done);
        end
    end

    // ------------------------------------------------------------------
    // Pause timer
    // ------------------------------------------------------------------
    // Holding issue idle saves pipeline power and avoids memory-order
    // replays when the spun-on location finally changes.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            pause_cnt_reg <= 8'h00;
            pause_reg     <= 1'b0;
        end else if (take && is_pause) begin
            pause_cnt_reg <= 8'(PAUSE_LEN);
            pause_reg     <= 1'b1;
        end else if (pausing) begin
            pause_cnt_reg <= pause_cnt_reg - 8'h01;
            pause_reg     <= pause_cnt_reg != 8'h01;
        end
    end

    // ------------------------------------------------------------------
    // Handshake, retirement and identification
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            req_ready_reg <= 1'b0;
            retire_reg    <= 1'b0;
            id_edx_reg    <= 32'h0000_0000;
        end else begin
            req_ready_reg <= 1'b1;
            retire_reg    <= take;
            if (id_query) begin
                id_edx_reg <= (id_leaf == ID_LEAF_FEATURES) ?
                              (32'h0000_0001 << FEAT_BIT) : 32'h0000_0000;
            end
        end
    end

    // Outputs straight from flip-flops.
    assign req_ready    = req_ready_reg;
    assign retire_pulse = retire_reg;
    assign mem_valid    = mem_valid_reg;
    assign mem_req      = mem_req_reg;
    assign id_edx       = id_edx_reg;
    assign pause_active = pause_reg;

endmodule : cfm_unit

`default_nettype wire

// ==== tb/cfm_unit_sva.sv ====
// Checker for the flush and fence unit, bound to its top-level ports.
// Assumes one core clock and the pause length of 8 set by the bench.
`timescale 1ns/1ps
`default_nettype none
module cfm_unit_sva
    import cfm_pkg::*;
#(
    parameter int PAUSE_LEN = 8
) (
    // Watched ports
    input wire logic         clock,
    input wire logic         rst_b,
    input wire cfm_req_t     req,
    input wire logic         retire_pulse,
    input wire logic         id_query,
    input wire logic [7:0]   id_leaf,
    input wire logic [31:0]  id_edx,
    input wire logic         mem_valid,
    input wire cfm_mem_req_t mem_req,
    input wire logic         mem_ready,
    input wire logic         mem_load_done,
    input wire logic         mem_store_done,
    input wire logic         pause_active
);
    // ----
    // Outstanding accesses seen at the memory side
    // ----
    // Counted from the handshake, so these never exceed what the unit holds.
    logic [4:0] ld_reg;
    logic [4:0] st_reg;
    wire logic  hs = mem_valid && mem_ready;
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            ld_reg <= 5'h0;
            st_reg <= 5'h0;
        end else begin
            ld_reg <= ld_reg + 5'(hs && mem_req.is_load) - 5'(mem_load_done);
            st_reg <= st_reg + 5'(hs && !mem_req.is_load) - 5'(mem_store_done);
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    AST_ID_FLAG: assert property (id_query |=> id_edx ==
        (($past(id_leaf) == ID_LEAF_FEATURES) ? 32'h0008_0000 : 32'h0))
        else $error("feature word wrong");
    AST_FLUSH: assert property (retire_pulse && $past(req.op) == CFM_OP_FLUSH
        |-> mem_valid && mem_req.is_flush && mem_req.broadcast && mem_req.addr == $past(req.addr))
        else $error("flush request malformed");
    AST_NT_VEC: assert property (retire_pulse
        && $past(req.op) inside {CFM_OP_NT_VEC_INT, CFM_OP_NT_VEC_DBL} |-> mem_valid
        && mem_req.no_alloc && mem_req.byte_en == 16'hffff && mem_req.data == $past(req.data))
        else $error("vector store malformed");
    AST_NT_GPR: assert property (retire_pulse && $past(req.op) == CFM_OP_NT_GPR
        |-> mem_valid && mem_req.no_alloc && mem_req.byte_en == 16'h000f
        && mem_req.data[31:0] == $past(req.data[31:0])) else $error("word store malformed");
    AST_MASKED: assert property (retire_pulse && $past(req.op) == CFM_OP_NT_MASKED
        |-> mem_valid && mem_req.no_alloc && mem_req.byte_en == $past(req.mask)
        && mem_req.addr == $past(req.addr)) else $error("masked store malformed");
    AST_LOAD_BAR: assert property (retire_pulse && $past(req.op) == CFM_OP_LOAD_BAR
        |-> $past(ld_reg) == 5'h0) else $error("load barrier passed pending loads");
    AST_FULL_BAR: assert property (retire_pulse
        && $past(req.op) inside {CFM_OP_FULL_BAR, CFM_OP_STORE_BAR}
        |-> $past(ld_reg) == 5'h0 && $past(st_reg) == 5'h0) else $error("full barrier too early");
    AST_PAUSE_LEN: assert property ($rose(pause_active)
        |-> pause_active [*8] ##1 !pause_active) else $error("pause length wrong");
    AST_PAUSE_HOLD: assert property ($rose(pause_active)
        |=> !retire_pulse [*7]) else $error("issue during pause");
    cover property (retire_pulse && $past(req.op) == CFM_OP_FULL_BAR);
    cover property ($rose(pause_active));
    cover property (mem_valid && mem_req.is_flush);
endmodule : cfm_unit_sva
`default_nettype wire

// ==== tb/cfm_mem_model.sv ====
// Memory side partner: random accept stalls, in-order completion pulses.
// Assumes one completion per accepted access; slow lowers the accept rate.
`timescale 1ns/1ps
`default_nettype none
module cfm_mem_model
    import cfm_pkg::*;
(
    // Clock, reset and pace
    input  wire logic          clock,
    input  wire logic          rst_b,
    input  wire logic          slow,
    // Memory side
    input  wire logic          mem_valid,
    input  wire cfm_mem_req_t  mem_req,
    output logic               mem_ready,
    output logic               mem_load_done,
    output logic               mem_store_done
);
    // ----
    // Acceptance and completion
    // ----
    bit q[$];
    initial begin
        mem_ready = 1'b0;
        mem_load_done = 1'b0;
        mem_store_done = 1'b0;
        forever begin
            @(posedge clock);
            if (rst_b && mem_valid && mem_ready) q.push_back(mem_req.is_load);
            #1;
            mem_load_done = 1'b0;
            mem_store_done = 1'b0;
            if (!rst_b) q.delete();
            else if (q.size() > 0 && $urandom_range(3) == 0) begin
                if (q.pop_front()) mem_load_done = 1'b1;
                else mem_store_done = 1'b1;
            end
            mem_ready = rst_b && (!slow || $urandom_range(3) == 0);
        end
    end
endmodule : cfm_mem_model
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the flush and fence unit.
// Assumes the memory model and checker compiled beside the design.
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import cfm_pkg::*;
;
    // ----
    // Stimulus, checks and verdict
    // ----
    logic clock = 1'b0, rst_b = 1'b0, req_valid = 1'b0, id_query = 1'b0, slow = 1'b0;
    logic [7:0] id_leaf = 8'h0;
    cfm_req_t req = '0;
    logic req_ready, retire_pulse, mem_valid, mem_ready, mem_load_done, mem_store_done;
    logic pause_active;
    logic [31:0] id_edx;
    cfm_mem_req_t mem_req;
    int n_mismatch = 0, n_tests = 0;
    cfm_unit #(.PAUSE_LEN(8)) DUT (.clock, .rst_b, .req_valid, .req, .req_ready, .retire_pulse,
        .id_query, .id_leaf, .id_edx, .mem_valid, .mem_req, .mem_ready, .mem_load_done,
        .mem_store_done, .pause_active);
    cfm_mem_model u_mem (.clock, .rst_b, .slow, .mem_valid, .mem_req, .mem_ready,
        .mem_load_done, .mem_store_done);
    task automatic chk(string what, logic [180:0] exp, logic [180:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Bytes outside the enables carry no meaning, so they are cleared on both sides.
    function automatic logic [127:0] keep(logic [127:0] d, logic [15:0] be);
        for (int b = 0; b < 16; b++) if (!be[b]) d[8*b +: 8] = 8'h0;
        return d;
    endfunction : keep
    function automatic cfm_mem_req_t exp_mem(cfm_req_t r);
        cfm_mem_req_t e;
        e = '0;
        e.addr = r.addr;
        e.is_load = (r.op == CFM_OP_LOAD);
        e.is_flush = (r.op == CFM_OP_FLUSH);
        e.broadcast = e.is_flush;
        e.no_alloc = r.op inside {CFM_OP_NT_VEC_INT, CFM_OP_NT_VEC_DBL, CFM_OP_NT_GPR,
            CFM_OP_NT_MASKED};
        e.byte_en = (r.op == CFM_OP_NT_MASKED) ? r.mask : (r.op == CFM_OP_NT_GPR) ? 16'h000f
            : (e.no_alloc || r.op == CFM_OP_STORE) ? 16'hffff : 16'h0;
        e.data = keep(r.data, e.byte_en);
        return e;
    endfunction : exp_mem
    // The request is dropped right after the retiring edge so it is not taken twice.
    task automatic issue(cfm_op_t op, logic [31:0] a, logic [127:0] d, logic [15:0] m);
        cfm_mem_req_t e;
        cfm_mem_req_t got;
        int k;
        @(posedge clock);
        #1;
        req = '{op, a, d, m};
        req_valid = 1'b1;
        k = 0;
        do begin
            @(posedge clock);
            #1;
            k++;
        end while (retire_pulse !== 1'b1 && k < 300);
        req_valid = 1'b0;
        chk("retire_pulse", 1'b1, retire_pulse);
        e = exp_mem(req);
        got = mem_req;
        got.data = keep(got.data, e.byte_en);
        if (op == CFM_OP_PAUSE) chk("pause_active", 1'b1, pause_active);
        if (op <= CFM_OP_NT_MASKED) chk("mem_req", {mem_valid, e}, {mem_valid, got});
    endtask : issue
    task automatic id_check(logic [7:0] leaf);
        @(posedge clock);
        #1;
        id_query = 1'b1;
        id_leaf = leaf;
        @(posedge clock);
        #1;
        id_query = 1'b0;
        chk("id_edx", (leaf == ID_LEAF_FEATURES) ? 32'h0008_0000 : 32'h0, id_edx);
    endtask : id_check
    task automatic end_of_test();
        $display("Counts: %0d comparisons, %0d mismatches", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test
    initial begin
        forever #2.5 clock = ~clock;
    end
    initial begin
        #(5 * 20000);
        n_mismatch++;
        end_of_test();
    end
    initial begin
        static cfm_op_t ops[10] = '{CFM_OP_LOAD, CFM_OP_FLUSH, CFM_OP_NT_VEC_INT,
            CFM_OP_NT_VEC_DBL, CFM_OP_NT_GPR, CFM_OP_NT_MASKED, CFM_OP_FULL_BAR,
            CFM_OP_STORE, CFM_OP_STORE_BAR, CFM_OP_LOAD_BAR};
        void'($urandom(32'h4453));
        repeat (12) @(posedge clock);
        #1 rst_b = 1'b1;
        chk("req_ready", 1'b0, req_ready);
        repeat (2) @(posedge clock);
        #1;
        chk("req_ready", 1'b1, req_ready);
        id_check(8'h01);
        id_check(8'h00);
        id_check(8'h02 + 8'($urandom_range(250)));
        $display("Test id done");
        // Loads pile up behind a slow memory so each barrier must really wait.
        slow = 1'b1;
        repeat (3) issue(CFM_OP_LOAD, $urandom, '0, '0);
        issue(CFM_OP_LOAD_BAR, '0, '0, '0);
        issue(CFM_OP_NT_MASKED, 32'h0000_1003, {4{$urandom}}, 16'ha5c3);
        issue(CFM_OP_FULL_BAR, '0, '0, '0);
        issue(CFM_OP_PAUSE, '0, '0, '0);
        issue(CFM_OP_NT_GPR, $urandom, {4{$urandom}}, '0);
        $display("Test ordering done");
        repeat (60) begin
            slow = 1'($urandom_range(1));
            issue(ops[$urandom_range(9)], $urandom, {4{$urandom}}, 16'($urandom));
        end
        $display("Test random done");
        end_of_test();
    end
endmodule : tb_top
bind cfm_unit cfm_unit_sva #(.PAUSE_LEN(PAUSE_LEN)) u_sva (.clock, .rst_b, .req, .retire_pulse,
    .id_query, .id_leaf, .id_edx, .mem_valid, .mem_req, .mem_ready, .mem_load_done,
    .mem_store_done, .pause_active);
`default_nettype wire
